// file: pkg/dsi3_codec_pkg.sv
`default_nettype none
package dsi3_codec_pkg;

    // Frame geometry.
    localparam int FRAME_BITS       = 32;
    localparam int MSG_BITS         = 24;
    localparam int CRC_W            = 8;
    localparam int NIBBLE_W         = 4;
    localparam int NIBBLES          = 8;
    localparam int CHIPS_PER_SYMBOL = 3;
    localparam int COUNT_W          = 6;

    // Command field positions within the 32-bit frame.
    localparam int ADDR_LSB = 28;
    localparam int OP_LSB   = 24;
    localparam int EXT_LSB  = 16;
    localparam int REGB_LSB = 8;
    localparam int CRC_LSB  = 0;

    // Counter limits at counter width.
    localparam logic [COUNT_W-1:0] FRAME_BITS_C = 6'h20;
    localparam logic [3:0]         LAST_NIBBLE  = 4'h7;
    localparam logic [1:0]         LAST_CHIP    = 2'h2;

    // CRC generator x^8 + x^5 + x^3 + x^2 + x + 1 and its all-ones seed.
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h2F;
    localparam logic [CRC_W-1:0] CRC_SEED = 8'hFF;

    // Cycles from the register read strobe until its data is sampled.
    localparam logic [1:0] REG_READ_WAIT = 2'h2;

    // Chip timing at the 20 MHz system clock.
    localparam int CLK_PERIOD_NS = 50;
    localparam int CHIP_TIME_NS  = 3000;
    localparam int CHIP_CYCLES   = (CHIP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHIP_CNT_W    = $clog2(CHIP_CYCLES);
    localparam logic [CHIP_CNT_W-1:0] CHIP_LAST = CHIP_CNT_W'(CHIP_CYCLES - 1);

    // Depth of the nibble buffer in front of the symbol encoder.
    localparam int FIFO_DEPTH = 4;

    // Chip levels, counted in response current steps above quiescent.
    localparam logic [1:0] CHIP_QUIET = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECEIVE,
        ST_CHECK,
        ST_READ,
        ST_GENERATE,
        ST_SEND
    } codec_state_t;

    // One serial CRC step: the bit enters the low end of the register.
    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] crc, input logic din);
        crc_step = {crc[CRC_W-2:0], din} ^ (crc[CRC_W-1] ? CRC_POLY : 8'h00);
    endfunction : crc_step

    // Nibble to three chips, first chip in the top two bits.
    function automatic logic [5:0] symbol_map(input logic [NIBBLE_W-1:0] nib);
        unique case (nib)
            4'h0: symbol_map = {2'h1, 2'h1, 2'h0};
            4'h1: symbol_map = {2'h2, 2'h1, 2'h1};
            4'h2: symbol_map = {2'h1, 2'h0, 2'h2};
            4'h3: symbol_map = {2'h2, 2'h0, 2'h2};
            4'h4: symbol_map = {2'h1, 2'h0, 2'h0};
            4'h5: symbol_map = {2'h2, 2'h1, 2'h2};
            4'h6: symbol_map = {2'h1, 2'h1, 2'h2};
            4'h7: symbol_map = {2'h2, 2'h0, 2'h1};
            4'h8: symbol_map = {2'h2, 2'h2, 2'h0};
            4'h9: symbol_map = {2'h2, 2'h1, 2'h0};
            4'hA: symbol_map = {2'h1, 2'h2, 2'h2};
            4'hB: symbol_map = {2'h2, 2'h2, 2'h1};
            4'hC: symbol_map = {2'h1, 2'h2, 2'h0};
            4'hD: symbol_map = {2'h2, 2'h0, 2'h0};
            4'hE: symbol_map = {2'h1, 2'h0, 2'h1};
            4'hF: symbol_map = {2'h1, 2'h2, 2'h1};
        endcase
    endfunction : symbol_map

endpackage : dsi3_codec_pkg
`default_nettype wire

// file: pkg/crc_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface crc_port_if;
    logic       load;
    logic       shift;
    logic       din;
    logic [7:0] remainder;
    logic       is_zero;

    modport user   (output load, output shift, output din, input remainder, input is_zero);
    modport engine (input load, input shift, input din, output remainder, output is_zero);
endinterface : crc_port_if
`default_nettype wire

// file: pkg/nibble_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface nibble_stream_if #(parameter int WIDTH = 4);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, input ready, output data);
    modport sink   (input valid, output ready, input data);
endinterface : nibble_stream_if
`default_nettype wire

// file: hdl/crc_shift_engine.sv
`timescale 1ns/1ns
`default_nettype none
module crc_shift_engine
    import dsi3_codec_pkg::*;
(
    input  wire logic  clk_sys_in,
    input  wire logic  rst_in,
    crc_port_if.engine crc_port
);
    import dsi3_codec_pkg::*;

    logic [CRC_W-1:0] crc_reg;
    logic [CRC_W-1:0] crc_next;

    assign crc_next = crc_port.load  ? CRC_SEED :
                      crc_port.shift ? crc_step(crc_reg, crc_port.din) : crc_reg;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            crc_reg <= CRC_SEED;
        else
            crc_reg <= crc_next;
    end

    assign crc_port.remainder = crc_reg;
    assign crc_port.is_zero   = (crc_reg == 8'h00);

endmodule : crc_shift_engine
`default_nettype wire

// file: hdl/stream_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    nibble_stream_if.sink   in_port,
    nibble_stream_if.source out_port
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_port.ready  = (count_reg != DEPTH_C);
    assign out_port.valid = (count_reg != '0);
    assign out_port.data  = mem[rd_ptr_reg];
    assign push           = in_port.valid & in_port.ready;
    assign pop            = out_port.valid & out_port.ready;

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_port.data;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
            if (push & ~pop)
                count_reg <= count_reg + 1'b1;
            else if (pop & ~push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule : stream_fifo
`default_nettype wire

// file: hdl/dsi3_crm_crc_response_codec.sv
// Summary of operation
// - CRC over all command bits, MSB first.
// - Failed CRC: drop command, send no response.
// - Seed register, shift message then CRC serially.
// - Zero remainder valid, nonzero means failure.
// - Polynomial 0x2F, seed FF every frame.
// - Response field one: own node address.
// - Response field two: echoed command opcode.
// - Field three: register at address plus one.
// - Field four: register at address plus zero.
// - Response CRC over frame, MSB first.
// - Shift message, append eight zeros, send remainder.
// - Each nibble becomes three three-level chips.
// - Fixed nibble to chip triple mapping table.
// - Chip value counts response current steps.
// - Command fields ordered; address must match ours.
`timescale 1ns/1ns
`default_nettype none
module dsi3_crm_crc_response_codec
    import dsi3_codec_pkg::*;
(
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    input  wire logic                 frame_start_in,
    input  wire logic                 cmd_bit_in,
    input  wire logic                 cmd_bit_valid_in,
    input  wire logic [3:0]           node_address_register_in,
    input  wire logic [15:0]          reg_data_in,
    output var  logic                 cmd_accepted_out,
    output var  logic                 crc_error_out,
    output var  logic [3:0]           opcode_out,
    output var  logic [7:0]           extended_byte_field_out,
    output var  logic [7:0]           register_byte_field_out,
    output var  logic                 reg_read_out,
    output var  logic [7:0]           register_byte_address_out,
    output var  logic [1:0]           response_current_step_out,
    output var  logic                 tx_active_out
);
    import dsi3_codec_pkg::*;

    crc_port_if                          check_port ();
    crc_port_if                          gen_port ();
    nibble_stream_if #(.WIDTH(NIBBLE_W)) push_port ();
    nibble_stream_if #(.WIDTH(NIBBLE_W)) pop_port ();

    codec_state_t              state_reg;
    codec_state_t              state_next;
    logic [FRAME_BITS-1:0]     rx_shift_reg;
    logic [COUNT_W-1:0]        bit_count_reg;
    logic [COUNT_W-1:0]        gen_count_reg;
    logic [MSG_BITS-1:0]       gen_shift_reg;
    logic [FRAME_BITS-1:0]     resp_reg;
    logic [3:0]                nib_count_reg;
    logic [1:0]                wait_count_reg;

    logic                      cmd_accepted_reg;
    logic                      crc_error_reg;
    logic [3:0]                opcode_reg;
    logic [7:0]                ext_byte_reg;
    logic [7:0]                reg_byte_reg;
    logic                      reg_read_reg;
    logic [7:0]                reg_addr_reg;

    logic                      tx_busy_reg;
    logic [5:0]                symbol_reg;
    logic [1:0]                chip_idx_reg;
    logic [CHIP_CNT_W-1:0]     chip_timer_reg;
    logic [1:0]                level_reg;

    logic                      rx_shift;
    logic                      frame_done;
    logic                      addr_match;
    logic                      accept;
    logic                      reject_crc;
    logic                      read_done;
    logic                      gen_done;
    logic                      nibble_push;
    logic                      last_push;
    logic [3:0]                rx_addr;
    logic [3:0]                rx_opcode;
    logic [7:0]                rx_ext_byte;
    logic [7:0]                rx_reg_byte;
    logic                      chip_end;
    logic                      symbol_end;
    logic                      symbol_load;
    logic [5:0]                symbol_new;
    logic [1:0]                next_chip_level;

    crc_shift_engine u_check_crc (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .crc_port   (check_port)
    );

    crc_shift_engine u_gen_crc (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .crc_port   (gen_port)
    );

    stream_fifo #(
        .WIDTH (NIBBLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_nibble_fifo (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .in_port    (push_port),
        .out_port   (pop_port)
    );

    // Command field split.
    assign rx_addr     = rx_shift_reg[ADDR_LSB +: 4];
    assign rx_opcode   = rx_shift_reg[OP_LSB +: 4];
    assign rx_ext_byte = rx_shift_reg[EXT_LSB +: 8];
    assign rx_reg_byte = rx_shift_reg[REGB_LSB +: 8];

    // Command checking: seed at frame start, then every received bit in arrival order.
    assign rx_shift   = (state_reg == ST_RECEIVE) & cmd_bit_valid_in & (bit_count_reg != FRAME_BITS_C);
    assign frame_done = (state_reg == ST_RECEIVE) & (bit_count_reg == FRAME_BITS_C);
    assign check_port.load  = frame_start_in & ((state_reg == ST_IDLE) | (state_reg == ST_RECEIVE));
    assign check_port.shift = rx_shift;
    assign check_port.din   = cmd_bit_in;

    // Accept only a zero remainder for our own address.
    assign addr_match = (rx_addr == node_address_register_in);
    assign accept     = (state_reg == ST_CHECK) & check_port.is_zero & addr_match;
    assign reject_crc = (state_reg == ST_CHECK) & ~check_port.is_zero;

    // Response generation: message bits first, then zeros fill in as the message shifts out.
    assign read_done = (state_reg == ST_READ) & (wait_count_reg == '0);
    assign gen_done  = (state_reg == ST_GENERATE) & (gen_count_reg == FRAME_BITS_C);
    assign gen_port.load  = read_done;
    assign gen_port.shift = (state_reg == ST_GENERATE) & (gen_count_reg != FRAME_BITS_C);
    assign gen_port.din   = gen_shift_reg[MSG_BITS-1];

    // Nibble hand-off into the buffer, most significant first.
    assign push_port.valid = (state_reg == ST_SEND);
    assign push_port.data  = resp_reg[FRAME_BITS-1 -: NIBBLE_W];
    assign nibble_push     = push_port.valid & push_port.ready;
    assign last_push       = nibble_push & (nib_count_reg == LAST_NIBBLE);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (frame_start_in)
                    state_next = ST_RECEIVE;
            ST_RECEIVE:
                if (frame_done & ~frame_start_in)
                    state_next = ST_CHECK;
            ST_CHECK:
                state_next = accept ? ST_READ : ST_IDLE;
            ST_READ:
                if (read_done)
                    state_next = ST_GENERATE;
            ST_GENERATE:
                if (gen_done)
                    state_next = ST_SEND;
            ST_SEND:
                if (last_push)
                    state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rx_shift_reg  <= '0;
            bit_count_reg <= '0;
        end
        else if (check_port.load)
            bit_count_reg <= '0;
        else if (rx_shift)
        begin
            rx_shift_reg  <= {rx_shift_reg[FRAME_BITS-2:0], cmd_bit_in};
            bit_count_reg <= bit_count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            wait_count_reg <= '0;
        else if (accept)
            wait_count_reg <= REG_READ_WAIT;
        else if ((state_reg == ST_READ) & (wait_count_reg != '0))
            wait_count_reg <= wait_count_reg - 1'b1;
    end

    // Response word assembly and its CRC.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            resp_reg      <= '0;
            gen_shift_reg <= '0;
            gen_count_reg <= '0;
            nib_count_reg <= '0;
        end
        else if (read_done)
        begin
            resp_reg[ADDR_LSB +: 4] <= node_address_register_in;
            resp_reg[OP_LSB +: 4]   <= opcode_reg;
            resp_reg[EXT_LSB +: 8]  <= reg_data_in[15:8];
            resp_reg[REGB_LSB +: 8] <= reg_data_in[7:0];
            gen_shift_reg <= {node_address_register_in, opcode_reg, reg_data_in};
            gen_count_reg <= '0;
            nib_count_reg <= '0;
        end
        else if (gen_port.shift)
        begin
            gen_shift_reg <= {gen_shift_reg[MSG_BITS-2:0], 1'b0};
            gen_count_reg <= gen_count_reg + 1'b1;
        end
        else if (gen_done)
            resp_reg[CRC_LSB +: CRC_W] <= gen_port.remainder;
        else if (nibble_push)
        begin
            resp_reg      <= {resp_reg[FRAME_BITS-NIBBLE_W-1:0], {NIBBLE_W{1'b0}}};
            nib_count_reg <= nib_count_reg + 1'b1;
        end
    end

    // Command report and register read request.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cmd_accepted_reg <= 1'b0;
            crc_error_reg    <= 1'b0;
            reg_read_reg     <= 1'b0;
            opcode_reg       <= '0;
            ext_byte_reg     <= '0;
            reg_byte_reg     <= '0;
            reg_addr_reg     <= '0;
        end
        else
        begin
            cmd_accepted_reg <= accept;
            crc_error_reg    <= reject_crc;
            reg_read_reg     <= accept;
            if (accept)
            begin
                opcode_reg   <= rx_opcode;
                ext_byte_reg <= rx_ext_byte;
                reg_byte_reg <= rx_reg_byte;
                reg_addr_reg <= {rx_ext_byte[7:1], 1'b0};
            end
        end
    end

    // Symbol encoder draining the buffer.
    assign chip_end        = tx_busy_reg & (chip_timer_reg == CHIP_LAST);
    assign symbol_end      = chip_end & (chip_idx_reg == LAST_CHIP);
    assign pop_port.ready  = ~tx_busy_reg | symbol_end;
    assign symbol_load     = pop_port.valid & pop_port.ready;
    assign symbol_new      = symbol_map(pop_port.data);
    assign next_chip_level = (chip_idx_reg == 2'h0) ? symbol_reg[3:2] : symbol_reg[1:0];

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            tx_busy_reg    <= 1'b0;
            symbol_reg     <= '0;
            chip_idx_reg   <= '0;
            chip_timer_reg <= '0;
            level_reg      <= CHIP_QUIET;
        end
        else if (symbol_load)
        begin
            tx_busy_reg    <= 1'b1;
            symbol_reg     <= symbol_new;
            chip_idx_reg   <= '0;
            chip_timer_reg <= '0;
            level_reg      <= symbol_new[5:4];
        end
        else if (symbol_end)
        begin
            tx_busy_reg    <= 1'b0;
            chip_timer_reg <= '0;
            level_reg      <= CHIP_QUIET;
        end
        else if (chip_end)
        begin
            chip_idx_reg   <= chip_idx_reg + 1'b1;
            chip_timer_reg <= '0;
            level_reg      <= next_chip_level;
        end
        else if (tx_busy_reg)
            chip_timer_reg <= chip_timer_reg + 1'b1;
    end

    // Outputs straight from flip-flops.
    assign cmd_accepted_out          = cmd_accepted_reg;
    assign crc_error_out             = crc_error_reg;
    assign opcode_out                = opcode_reg;
    assign extended_byte_field_out   = ext_byte_reg;
    assign register_byte_field_out   = reg_byte_reg;
    assign reg_read_out              = reg_read_reg;
    assign register_byte_address_out = reg_addr_reg;
    assign response_current_step_out = level_reg;
    assign tx_active_out             = tx_busy_reg;

endmodule : dsi3_crm_crc_response_codec
`default_nettype wire

// file: test/crm_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module crm_master_model (
    input  wire logic clk_sys_in,
    output var  logic frame_start_out,
    output var  logic cmd_bit_out,
    output var  logic cmd_bit_valid_out
);
    initial
    begin
        frame_start_out   = 1'b0;
        cmd_bit_out       = 1'b0;
        cmd_bit_valid_out = 1'b0;
    end

    // Serial CRC seeded with all ones; message, then eight zeros.
    function automatic logic [7:0] crc8(input logic [23:0] msg);
        logic [31:0] m;
        logic [7:0]  c;
        m = {msg, 8'h00};
        c = 8'hFF;
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], m[i]} ^ (c[7] ? 8'h2F : 8'h00);
        return c;
    endfunction : crc8

    // Sends the top nbits of a frame, MSB first.
    task automatic send(input logic [31:0] frame, input int nbits, gap);
        @(negedge clk_sys_in);
        frame_start_out = 1'b1;
        @(negedge clk_sys_in);
        frame_start_out = 1'b0;
        for (int i = 31; i > 31 - nbits; i--)
        begin
            cmd_bit_valid_out = 1'b1;
            cmd_bit_out       = frame[i];
            @(negedge clk_sys_in);
            if (gap > 0 && i > 32 - nbits)
            begin
                cmd_bit_valid_out = 1'b0;
                cmd_bit_out       = ~cmd_bit_out;
                repeat (gap) @(negedge clk_sys_in);
            end
        end
        cmd_bit_valid_out = 1'b0;
        cmd_bit_out       = ~cmd_bit_out;
    endtask : send
endmodule : crm_master_model
`default_nettype wire

// file: test/dsi3_codec_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dsi3_codec_sva
    import dsi3_codec_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        frame_start_in,
    input wire logic        cmd_bit_in,
    input wire logic        cmd_bit_valid_in,
    input wire logic [3:0]  node_address_register_in,
    input wire logic [15:0] reg_data_in,
    input wire logic        cmd_accepted_out,
    input wire logic        crc_error_out,
    input wire logic [3:0]  opcode_out,
    input wire logic [7:0]  extended_byte_field_out,
    input wire logic [7:0]  register_byte_field_out,
    input wire logic        reg_read_out,
    input wire logic [7:0]  register_byte_address_out,
    input wire logic [1:0]  response_current_step_out,
    input wire logic        tx_active_out
);
    logic [31:0]           sh_reg;
    logic [7:0]            crc_reg;
    logic [5:0]            cnt_reg;
    logic [CHIP_CNT_W-1:0] chip_reg;
    logic [10:0]           len_reg;
    logic                  pend_reg;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || frame_start_in)
        begin
            cnt_reg <= 6'h00;
            crc_reg <= 8'hFF;
        end
        else if (cmd_bit_valid_in && cnt_reg < 6'h20)
        begin
            cnt_reg <= cnt_reg + 6'h01;
            crc_reg <= {crc_reg[6:0], cmd_bit_in} ^ (crc_reg[7] ? 8'h2F : 8'h00);
            sh_reg  <= {sh_reg[30:0], cmd_bit_in};
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        chip_reg <= (!tx_active_out || chip_reg == CHIP_LAST) ? '0 : chip_reg + 1'b1;
        len_reg  <= tx_active_out ? len_reg + 11'h001 : 11'h000;
        pend_reg <= !rst_in && (cmd_accepted_out || (pend_reg && !tx_active_out));
    end

    a_crc_verdict: assert property ($rose(cnt_reg == 6'h20) |-> ##2 crc_error_out == (crc_reg != 8'h00))
        else $error("CRC verdict wrong");
    a_accept_verdict: assert property ($rose(cnt_reg == 6'h20) |-> ##2
        cmd_accepted_out == (crc_reg == 8'h00 && sh_reg[31:28] == node_address_register_in))
        else $error("Accept wrong");
    a_field_echo: assert property (cmd_accepted_out |-> opcode_out == sh_reg[27:24] &&
        extended_byte_field_out == sh_reg[23:16] && register_byte_field_out == sh_reg[15:8])
        else $error("Fields wrong");
    a_read_address: assert property (cmd_accepted_out |-> reg_read_out &&
        register_byte_address_out == {sh_reg[23:17], 1'b0})
        else $error("Read wrong");
    a_tx_needs_accept: assert property ($rose(tx_active_out) |-> pend_reg)
        else $error("Unrequested response");
    a_accept_to_tx: assert property (cmd_accepted_out |-> ##[1:200] $rose(tx_active_out))
        else $error("No response");
    a_idle_quiet: assert property (!tx_active_out |-> response_current_step_out == CHIP_QUIET)
        else $error("Idle current");
    a_level_range: assert property (response_current_step_out != 2'h3)
        else $error("Bad level");
    a_first_nonnull: assert property ($rose(tx_active_out) |-> response_current_step_out != 2'h0)
        else $error("Null first chip");
    a_chip_hold: assert property (tx_active_out && chip_reg != '0 |-> $stable(response_current_step_out))
        else $error("Chip too short");
    a_frame_length: assert property ($fell(tx_active_out) |-> len_reg == 11'd1440)
        else $error("Bad length");
endmodule : dsi3_codec_sva

bind dsi3_crm_crc_response_codec dsi3_codec_sva u_sva (.clk_sys_in, .rst_in, .frame_start_in, .cmd_bit_in,
    .cmd_bit_valid_in, .node_address_register_in, .reg_data_in, .cmd_accepted_out, .crc_error_out, .opcode_out,
    .extended_byte_field_out, .register_byte_field_out, .reg_read_out, .register_byte_address_out,
    .response_current_step_out, .tx_active_out);
`default_nettype wire

// file: test/dsi3_crm_crc_response_codec_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dsi3_crm_crc_response_codec_tb_top;
    import dsi3_codec_pkg::*;
    localparam logic [5:0] SYM [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16, 6'h21,
                                        6'h28, 6'h24, 6'h1A, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};
    localparam logic [23:0] MSG_TAB [4] = '{24'h181186, 24'h2125FF, 24'h3F1A41, 24'h410101};
    localparam logic [7:0]  CRC_TAB [4] = '{8'hB0, 8'h38, 8'h2C, 8'hD4};
    localparam logic [15:0] RD_TAB [4]  = '{16'h0123, 16'h4567, 16'h89AB, 16'hCDEF};
    logic        clk_sys_in, rst_in, frame_start_in, cmd_bit_in, cmd_bit_valid_in;
    logic        cmd_accepted_out, crc_error_out, reg_read_out, tx_active_out;
    logic [3:0]  node_in, opcode_out;
    logic [15:0] reg_data_in;
    logic [7:0]  ext_out, regb_out, addr_out, m8;
    logic [1:0]  level_out;
    logic [23:0] msg;
    int          fails, cmp_count, flip;

    crm_master_model u_master (.clk_sys_in, .frame_start_out(frame_start_in), .cmd_bit_out(cmd_bit_in),
        .cmd_bit_valid_out(cmd_bit_valid_in));
    dsi3_crm_crc_response_codec uut (.clk_sys_in, .rst_in, .frame_start_in, .cmd_bit_in, .cmd_bit_valid_in,
        .node_address_register_in(node_in), .reg_data_in, .cmd_accepted_out, .crc_error_out, .opcode_out,
        .extended_byte_field_out(ext_out), .register_byte_field_out(regb_out), .reg_read_out,
        .register_byte_address_out(addr_out), .response_current_step_out(level_out), .tx_active_out);

    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    task automatic check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // Sends one command and checks every result.
    task automatic run(input logic [31:0] frame, input logic [3:0] node, input logic [15:0] rd,
                       input int gap, input logic acc, err);
        logic        a = 1'b0;
        logic        e = 1'b0;
        logic [31:0] resp;
        int          i;
        node_in = node;
        reg_data_in = rd;
        u_master.send(frame, 32, gap);
        repeat (4)
        begin
            @(negedge clk_sys_in);
            a = a | (cmd_accepted_out & reg_read_out);
            e = e | crc_error_out;
        end
        check(a, acc);
        check(e, err);
        if (acc)
        begin
            check(opcode_out, frame[27:24]);
            check({ext_out, regb_out}, frame[23:8]);
            check(addr_out, {frame[23:17], 1'b0});
            resp = {node, frame[27:24], rd, u_master.crc8({node, frame[27:24], rd})};
            i = 0;
            while (tx_active_out !== 1'b1 && i < 300)
            begin
                @(negedge clk_sys_in);
                i++;
            end
            repeat (30) @(negedge clk_sys_in);
            for (int k = 0; k < 24; k++)
            begin
                check(level_out, SYM[resp[31-4*(k/3) -: 4]][5-2*(k%3) -: 2]);
                repeat (60) @(negedge clk_sys_in);
            end
            check({tx_active_out, level_out}, 3'h0);
        end
        else
        begin
            a = 1'b0;
            repeat (150)
            begin
                @(negedge clk_sys_in);
                a = a | tx_active_out;
            end
            check(a, 1'b0);
        end
    endtask : run

    initial
    begin
        rst_in = 1'b1;
        node_in = 4'h0;
        reg_data_in = 16'h0000;
        void'($urandom(32'h70756ed9));
        repeat (6) @(negedge clk_sys_in);
        rst_in = 1'b0;
        check({cmd_accepted_out, crc_error_out, tx_active_out, level_out}, 5'h00);
        for (int t = 0; t < 4; t++)
            run({MSG_TAB[t], CRC_TAB[t]}, 4'(t + 1), RD_TAB[t], t % 3, 1'b1, 1'b0);
        run({MSG_TAB[0], CRC_TAB[0] ^ 8'h01}, 4'h1, 16'h5AA5, 0, 1'b0, 1'b1);
        run({MSG_TAB[1], CRC_TAB[1]}, 4'h5, 16'h1234, 1, 1'b0, 1'b0);
        m8 = u_master.crc8(24'h002000);
        run({24'h002000, m8}, 4'h3, 16'h1234, 0, 1'b0, 1'b0);
        u_master.send($urandom, 12, 0);
        run({MSG_TAB[3], CRC_TAB[3]}, 4'h4, 16'hFEDC, 0, 1'b1, 1'b0);
        for (int t = 0; t < 4; t++)
        begin
            msg = 24'($urandom);
            flip = $urandom % 2;
            m8 = u_master.crc8(msg) ^ 8'(flip << ($urandom % 8));
            run({msg, m8}, msg[23:20], 16'($urandom), $urandom % 3, flip == 0, flip != 0);
        end
        tally_and_finish();
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys_in);
        fails++;
        tally_and_finish();
    end
endmodule : dsi3_crm_crc_response_codec_tb_top
`default_nettype wire
